// ===== verilog/lcdc_top.sv
// Command interpreter and host port of the LCD driver
// What this block does
// - Data write stores byte, then column increments
// - Data read returns byte, then column advances
// - First read after addressing returns stale latch
// - Serial interface selected: no read path
// - Segment direction from D0, increment unchanged
// - Inverse display from D0, RAM kept
// - All-on from D0 overrides inverse
// - Bias set applies only with follower on
// - Read-modify-write: reads hold, writes increment
// - End command restores saved column address
// - Soft reset restores address, row scan, ratio and contrast defaults, RAM untouched
// - Row scan direction from D3
// - Booster, regulator, follower enables from D2..D0
// - Three-bit resistor ratio from D2..D0
// - Contrast byte loads six low bits
// - After contrast mode, next command is value
// - Column saturates at top, page never advances
`timescale 1ns/10ps
module lcdc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic cmd_data_select,
  input wire logic serial_select,
  input wire logic serial_data,
  input wire logic serial_clk,
  input wire logic serial_cs_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [lcdc_pkg::PAGE_W-1:0] scan_page,
  input wire logic [lcdc_pkg::COL_W-1:0] scan_col,
  output logic [7:0] scan_pixels,
  output logic segment_reverse,
  output logic display_inverse,
  output logic all_on,
  output logic bias_applied,
  output logic row_scan_reverse,
  output logic booster_en,
  output logic regulator_en,
  output logic follower_en,
  output logic [2:0] resistor_ratio,
  output logic [5:0] contrast,
  output logic [lcdc_pkg::COL_W-1:0] column_addr,
  output logic [lcdc_pkg::PAGE_W-1:0] page_addr,
  output logic rmw_active,
  output logic contrast_pending
);
  import lcdc_pkg::*;

  logic [PIN_W-1:0] pins;       // Raw pins in vector form
  logic [PIN_W-1:0] sync1;      // First stage, read only by sync2
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] filt;       // Agreed pin levels
  logic [PIN_W-1:0] filt_d;     // Previous agreed levels
  logic [7:0] shift;            // Serial assembly
  logic [3:0] bit_cnt;          // Serial bits taken
  logic byte_evt;               // One complete host byte
  logic [7:0] byte_val;
  logic byte_dc;                // Byte was data, not command
  logic bias_sel;               // Last requested bias
  logic [COL_W-1:0] saved_col;  // Column at RMW entry
  logic [7:0] read_latch;       // Output latch of the read pipeline
  lcdc_rd_e rd_state;
  logic [7:0] host_rdata;
  logic [7:0] scan_rdata;
  logic [COL_W-1:0] mapped_col;
  logic wr_rise;
  logic rd_rise;
  logic rd_fall;
  logic sclk_rise;
  logic cmd_evt;
  logic data_wr;
  logic contrast_load;
  logic rd_advance;
  logic [COL_W-1:0] col_inc;
  lcdc_cmd_e kind;

  assign pins = {data_in, serial_cs_n, serial_clk, serial_data, serial_select,
                 cmd_data_select, rd_strobe_n, wr_strobe_n};

  // Three-stage sync with agreement filter on every pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi] <= PIN_IDLE[gi];
          sync2[gi] <= PIN_IDLE[gi];
          sync3[gi] <= PIN_IDLE[gi];
          filt[gi] <= PIN_IDLE[gi];
          filt_d[gi] <= PIN_IDLE[gi];
        end else if (ce) begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          // Only a level that two stages agree on counts
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
          filt_d[gi] <= filt[gi];
        end
      end
    end
  endgenerate

  assign wr_rise = filt[P_WR] & ~filt_d[P_WR];
  assign rd_rise = filt[P_RD] & ~filt_d[P_RD];
  assign rd_fall = ~filt[P_RD] & filt_d[P_RD];
  assign sclk_rise = filt[P_SCLK] & ~filt_d[P_SCLK];

  // Byte assembly: parallel at end of write strobe, serial MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_evt <= 1'b0;
      byte_val <= 8'h00;
      byte_dc <= 1'b0;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
    end else if (ce) begin
      byte_evt <= 1'b0;
      if (!filt[P_SMODE]) begin
        bit_cnt <= 4'h0;
        if (wr_rise) begin
          byte_evt <= 1'b1;
          byte_val <= filt[P_D0 +: BITS_PER_BYTE];
          byte_dc <= filt[P_DC];
        end
      end else if (filt[P_SCS]) begin
        // Deselect abandons a partial byte
        bit_cnt <= 4'h0;
      end else if (sclk_rise) begin
        shift <= {shift[6:0], filt[P_SDATA]};
        if (bit_cnt == BIT_LAST) begin
          bit_cnt <= 4'h0;
          byte_evt <= 1'b1;
          byte_val <= {shift[6:0], filt[P_SDATA]};
          byte_dc <= filt[P_DC];
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // Contrast mode swallows the next command byte
  assign kind = lcdc_decode(byte_val);
  assign cmd_evt = byte_evt & ~byte_dc & ~contrast_pending;
  assign contrast_load = byte_evt & ~byte_dc & contrast_pending;
  assign data_wr = byte_evt & byte_dc;
  assign rd_advance = (rd_state == LCDC_RD_LATCH) & ~rmw_active;
  // Saturating step: the page is never touched here
  assign col_inc = (column_addr == COL_MAX) ? COL_MAX : column_addr + COL_ONE;

  // Display configuration; undecoded bytes fall through untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      segment_reverse <= 1'b0;
      display_inverse <= 1'b0;
      all_on <= 1'b0;
      bias_sel <= BIAS_RST;
      row_scan_reverse <= 1'b0;
      booster_en <= 1'b0;
      regulator_en <= 1'b0;
      follower_en <= 1'b0;
    end else if (ce && cmd_evt) begin
      case (kind)
        LCDC_SEG: segment_reverse <= byte_val[B_D0];
        LCDC_INV: display_inverse <= byte_val[B_D0];
        LCDC_ALLON: all_on <= byte_val[B_D0];
        LCDC_BIAS: bias_sel <= byte_val[B_D0];
        LCDC_SCAN: row_scan_reverse <= byte_val[B_D3];
        LCDC_SOFT_RST: row_scan_reverse <= 1'b0;
        LCDC_POWER: begin
          booster_en <= byte_val[B_BOOST];
          regulator_en <= byte_val[B_REG];
          follower_en <= byte_val[B_FOLLOW];
        end
        default: begin
          // Nothing else here
        end
      endcase
    end
  end

  // Bias reaches the supply only while the follower runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_applied <= BIAS_RST;
    end else if (ce && follower_en) begin
      bias_applied <= bias_sel;
    end
  end

  // Regulator ratio and contrast value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resistor_ratio <= RATIO_RST;
      contrast <= CONTRAST_RST;
      contrast_pending <= 1'b0;
    end else if (ce) begin
      if (contrast_load) begin
        contrast <= byte_val[5:0];
        contrast_pending <= 1'b0;
      end else if (cmd_evt && kind == LCDC_CONTRAST) begin
        contrast_pending <= 1'b1;
      end else if (cmd_evt && kind == LCDC_RATIO) begin
        resistor_ratio <= byte_val[2:0];
      end else if (cmd_evt && kind == LCDC_SOFT_RST) begin
        resistor_ratio <= RATIO_RST;
        contrast <= CONTRAST_RST;
      end
    end
  end

  // Addressing and read-modify-write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      column_addr <= COL_RST;
      page_addr <= PAGE_RST;
      rmw_active <= 1'b0;
      saved_col <= COL_RST;
    end else if (ce) begin
      if (cmd_evt && kind == LCDC_SOFT_RST) begin
        column_addr <= COL_RST;
        page_addr <= PAGE_RST;
        rmw_active <= 1'b0;
      end else if (cmd_evt && kind == LCDC_RMW_ON) begin
        rmw_active <= 1'b1;
        saved_col <= column_addr;
      end else if (cmd_evt && kind == LCDC_RMW_OFF) begin
        rmw_active <= 1'b0;
        column_addr <= saved_col;
      end else if (data_wr || rd_advance) begin
        column_addr <= col_inc;
      end
    end
  end

  // Read pipeline: the strobe shows the previous fetch, then refetches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state <= LCDC_RD_IDLE;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
      read_latch <= 8'h00;
    end else if (ce) begin
      case (rd_state)
        LCDC_RD_IDLE: begin
          // Serial mode has no read path at all
          if (rd_fall && filt[P_DC] && !filt[P_SMODE]) begin
            data_out <= read_latch;
            data_oe_n <= 1'b0;
            rd_state <= LCDC_RD_DRIVE;
          end
        end
        LCDC_RD_DRIVE: begin
          if (rd_rise || filt[P_SMODE]) begin
            data_oe_n <= 1'b1;
            rd_state <= LCDC_RD_FETCH;
          end
        end
        LCDC_RD_FETCH: rd_state <= LCDC_RD_LATCH;
        LCDC_RD_LATCH: begin
          read_latch <= host_rdata;
          rd_state <= LCDC_RD_IDLE;
        end
        default: rd_state <= LCDC_RD_IDLE;
      endcase
    end
  end

  // Reversed order maps column n to the mirrored segment
  assign mapped_col = segment_reverse ? SEG_LAST - scan_col : scan_col;

  lcdc_ram u_ram (
    .clk(clk),
    .ce(ce),
    .we(data_wr),
    .host_addr({page_addr, column_addr}),
    .wdata(byte_val),
    .host_rdata(host_rdata),
    .scan_addr({scan_page, mapped_col}),
    .scan_rdata(scan_rdata)
  );

  // Pixel polarity; all-on wins over inverse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_pixels <= 8'h00;
    end else if (ce) begin
      if (all_on) begin
        scan_pixels <= 8'hff;
      end else begin
        scan_pixels <= display_inverse ? ~scan_rdata : scan_rdata;
      end
    end
  end

  a_wr_col_inc: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && data_wr && column_addr != COL_MAX) |=> column_addr == $past(column_addr) + COL_ONE)
    else $error("column did not step after write");
  a_col_saturate: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && data_wr && column_addr == COL_MAX) |=> column_addr == COL_MAX && $stable(page_addr))
    else $error("column left its top value");
  a_rmw_read_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && rmw_active && rd_state == LCDC_RD_LATCH && !byte_evt) |=> $stable(column_addr))
    else $error("read moved column in rmw mode");
  a_rmw_restore: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cmd_evt && kind == LCDC_RMW_OFF) |=> column_addr == $past(saved_col) && !rmw_active)
    else $error("end did not restore column");
  a_contrast_load: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && contrast_load) |=> contrast == $past(byte_val[5:0]) && !contrast_pending)
    else $error("contrast value not loaded");
  a_contrast_only: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && contrast_load) |=> $stable(display_inverse) && $stable(rmw_active))
    else $error("command acted during contrast mode");
  a_serial_no_read: assert property (@(posedge clk) disable iff (!rst_n)
    (filt[P_SMODE] && rd_state == LCDC_RD_IDLE) |=> data_oe_n)
    else $error("read driven in serial mode");
  a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cmd_evt && kind == LCDC_SOFT_RST) |=> column_addr == COL_RST && !rmw_active
      && contrast == CONTRAST_RST && resistor_ratio == RATIO_RST)
    else $error("soft reset left state");
  a_all_on_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && all_on) |=> scan_pixels == 8'hff)
    else $error("all-on did not light pixels");
  a_bias_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !follower_en) |=> $stable(bias_applied))
    else $error("bias changed with follower off");

endmodule : lcdc_top

// ===== verilog/lcdc_pkg.sv
// Shared constants and types of the LCD command decoder
package lcdc_pkg;

  // Display memory geometry
  localparam int PAGE_W = 4;                   // Page address width
  localparam int COL_W = 8;                    // Column address width
  localparam int ADDR_W = PAGE_W + COL_W;      // Flat memory address width
  localparam int PAGES = 9;                    // Pages 0 to 8
  localparam int COLS = 256;                   // Columns per page
  localparam int RAM_DEPTH = PAGES * COLS;     // Bytes held
  localparam logic [COL_W-1:0] COL_MAX = 8'hff;    // Increment stops here
  localparam logic [COL_W-1:0] SEG_LAST = 8'hc7;   // Last segment for reversed order
  localparam logic [COL_W-1:0] COL_ONE = 8'h01;    // Increment step

  // Reset values
  localparam logic [COL_W-1:0] COL_RST = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 4'h0;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [5:0] CONTRAST_RST = 6'h20;
  localparam logic BIAS_RST = 1'b0;            // 0 is 1/9 bias, 1 is 1/7

  // Synchronised pin vector layout
  localparam int P_WR = 0;                     // Write strobe, active low
  localparam int P_RD = 1;                     // Read strobe, active low
  localparam int P_DC = 2;                     // Command/data select
  localparam int P_SMODE = 3;                  // Serial interface select
  localparam int P_SDATA = 4;                  // Serial data
  localparam int P_SCLK = 5;                   // Serial clock
  localparam int P_SCS = 6;                    // Serial chip select, active low
  localparam int P_D0 = 7;                     // Parallel data bit 0
  localparam int PIN_W = 15;
  localparam logic [PIN_W-1:0] PIN_IDLE = 15'h0043;  // Strobes and select idle high

  // Command field positions
  localparam int B_D0 = 0;
  localparam int B_D3 = 3;
  localparam int B_BOOST = 2;
  localparam int B_REG = 1;
  localparam int B_FOLLOW = 0;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;

  // Command codes and masks
  localparam logic [7:0] OP_SEG = 8'ha0;
  localparam logic [7:0] OP_INV = 8'ha6;
  localparam logic [7:0] OP_ALLON = 8'ha4;
  localparam logic [7:0] OP_BIAS = 8'ha2;
  localparam logic [7:0] OP_RMW_ON = 8'he0;
  localparam logic [7:0] OP_RMW_OFF = 8'hee;
  localparam logic [7:0] OP_SOFT_RST = 8'he2;
  localparam logic [7:0] OP_SCAN = 8'hc0;
  localparam logic [7:0] OP_POWER = 8'h28;
  localparam logic [7:0] OP_RATIO = 8'h20;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] M_BIT0 = 8'hfe;       // Low bit is the argument
  localparam logic [7:0] M_FULL = 8'hff;       // Exact match
  localparam logic [7:0] M_NIBBLE = 8'hf0;     // Low nibble free
  localparam logic [7:0] M_LOW3 = 8'hf8;       // Low three bits are the argument

  typedef enum logic [3:0] {
    LCDC_NONE, LCDC_SEG, LCDC_INV, LCDC_ALLON, LCDC_BIAS, LCDC_RMW_ON, LCDC_RMW_OFF,
    LCDC_SOFT_RST, LCDC_SCAN, LCDC_POWER, LCDC_RATIO, LCDC_CONTRAST
  } lcdc_cmd_e;

  typedef enum logic [1:0] {
    LCDC_RD_IDLE, LCDC_RD_DRIVE, LCDC_RD_FETCH, LCDC_RD_LATCH
  } lcdc_rd_e;

  // Classify a command byte
  function automatic lcdc_cmd_e lcdc_decode(input logic [7:0] b);
    lcdc_cmd_e k;
    k = LCDC_NONE;
    if ((b & M_BIT0) == OP_SEG) begin
      k = LCDC_SEG;
    end else if ((b & M_BIT0) == OP_INV) begin
      k = LCDC_INV;
    end else if ((b & M_BIT0) == OP_ALLON) begin
      k = LCDC_ALLON;
    end else if ((b & M_BIT0) == OP_BIAS) begin
      k = LCDC_BIAS;
    end else if ((b & M_FULL) == OP_RMW_ON) begin
      k = LCDC_RMW_ON;
    end else if ((b & M_FULL) == OP_RMW_OFF) begin
      k = LCDC_RMW_OFF;
    end else if ((b & M_FULL) == OP_SOFT_RST) begin
      k = LCDC_SOFT_RST;
    end else if ((b & M_NIBBLE) == OP_SCAN) begin
      k = LCDC_SCAN;
    end else if ((b & M_LOW3) == OP_POWER) begin
      k = LCDC_POWER;
    end else if ((b & M_LOW3) == OP_RATIO) begin
      k = LCDC_RATIO;
    end else if ((b & M_FULL) == OP_CONTRAST) begin
      k = LCDC_CONTRAST;
    end
    return k;
  endfunction : lcdc_decode

endpackage : lcdc_pkg

// ===== verilog/lcdc_ram.sv
// Dual-read display memory with registered read data
`timescale 1ns/10ps
module lcdc_ram (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [lcdc_pkg::ADDR_W-1:0] host_addr,
  input wire logic [7:0] wdata,
  output logic [7:0] host_rdata,
  input wire logic [lcdc_pkg::ADDR_W-1:0] scan_addr,
  output logic [7:0] scan_rdata
);
  import lcdc_pkg::*;

  logic [7:0] mem [0:RAM_DEPTH-1];  // No reset: contents survive soft reset

  // Host port, write then read-first
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[host_addr] <= wdata;
      end
      host_rdata <= mem[host_addr];
    end
  end

  // Display scan port
  always_ff @(posedge clk) begin
    if (ce) begin
      scan_rdata <= mem[scan_addr];
    end
  end

endmodule : lcdc_ram

// ===== tb/lcdc_host.sv
// Host processor model driving the parallel byte port
`timescale 1ns/10ps
module lcdc_host (
  input wire logic clk,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic cmd_data_select,
  output logic serial_data,
  output logic serial_clk,
  output logic serial_cs_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  // Idle bus: strobes high
  initial begin
    wr_strobe_n = 1'b1;
    rd_strobe_n = 1'b1;
    cmd_data_select = 1'b0;
    data_in = 8'h5a;
    // Serial port idle: deselected, clock low
    serial_data = 1'b0;
    serial_clk = 1'b0;
    serial_cs_n = 1'b1;
  end

  // Wait a number of rising edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One byte write; pairs are issued as adjacent calls
  // No column set is ever issued in read-modify-write
  task automatic wr(input logic dc, input logic [7:0] b);
    cmd_data_select <= dc;
    data_in <= b;
    cyc(6);
    wr_strobe_n <= 1'b0;
    cyc(5);
    wr_strobe_n <= 1'b1;
    cyc(6);
    // Released bus must not keep the last byte
    data_in <= ~b;
    cyc(2);
  endtask : wr

  // One data read; strobe held until the bus has settled
  task automatic rd(output logic [7:0] q, output logic oe_n);
    cmd_data_select <= 1'b1;
    cyc(6);
    rd_strobe_n <= 1'b0;
    cyc(8);
    // A released bus reads as the inverse, so a missing drive shows up
    q = data_oe_n ? ~data_out : data_out;
    oe_n = data_oe_n;
    rd_strobe_n <= 1'b1;
    // Fetch and latch finish after the filtered rise
    cyc(10);
  endtask : rd

  // One serial byte, MSB first; each clock level held five cycles
  task automatic swr(input logic dc, input logic [7:0] b);
    cmd_data_select <= dc;
    serial_cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_data <= b[i];
      cyc(5);
      serial_clk <= 1'b1;
      cyc(5);
      serial_clk <= 1'b0;
    end
    // Let the last bit land before deselecting
    cyc(6);
    serial_cs_n <= 1'b1;
    serial_data <= ~b[0];
    cyc(2);
  endtask : swr
endmodule : lcdc_host

// ===== tb/test_lcdc_top.sv
// Self-checking bench of the LCD command decoder
`timescale 1ns/10ps
module test_lcdc_top;
  import lcdc_pkg::*;
  logic clk, rst_n, ce, serial_select, wr_strobe_n, rd_strobe_n, cmd_data_select;
  logic data_oe_n, segment_reverse, display_inverse, all_on, bias_applied, oe;
  logic row_scan_reverse, booster_en, regulator_en, follower_en, rmw_active;
  logic contrast_pending, breq;
  logic serial_data, serial_clk, serial_cs_n;
  logic [7:0] data_in, data_out, scan_pixels, q, b, e, cfg;
  logic [PAGE_W-1:0] scan_page, page_addr;
  logic [COL_W-1:0] scan_col, column_addr;
  logic [2:0] resistor_ratio, ratio;
  logic [5:0] contrast;
  logic [7:0] mem [256]; // Expected page 0 bytes
  logic [7:0] ops [8] = '{8'ha0, 8'ha6, 8'ha4, 8'ha2, 8'hc0, 8'h28, 8'h20, 8'hff};
  logic [7:0] msk [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h0f, 8'h07, 8'h07, 8'h00};
  logic [31:0] seed = 32'h2e5d; // Fixed seed keeps runs repeatable
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Packed config levels, same order as the expected vector
  assign cfg = {segment_reverse, display_inverse, all_on, bias_applied,
                row_scan_reverse, booster_en, regulator_en, follower_en};

  lcdc_top dut_u (
    .clk, .rst_n, .ce, .wr_strobe_n, .rd_strobe_n, .cmd_data_select, .serial_select,
    .serial_data, .serial_clk, .serial_cs_n, .data_in, .data_out,
    .data_oe_n, .scan_page, .scan_col, .scan_pixels, .segment_reverse, .display_inverse,
    .all_on, .bias_applied, .row_scan_reverse, .booster_en, .regulator_en, .follower_en,
    .resistor_ratio, .contrast, .column_addr, .page_addr, .rmw_active, .contrast_pending
  );

  lcdc_host host_u (
    .clk, .wr_strobe_n, .rd_strobe_n, .cmd_data_select, .serial_data, .serial_clk,
    .serial_cs_n, .data_in, .data_out, .data_oe_n
  );

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard; the full run needs roughly 6400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end

  // Xorshift source
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  // Pixel after polarity; all-on wins over inverse
  function automatic logic [7:0] pix(input logic [7:0] m, input logic inv, input logic on);
    return on ? 8'hff : (inv ? ~m : m);
  endfunction : pix

  // Expected config after one command byte
  task automatic model(input logic [7:0] c);
    if (c[7:1] == 7'h50) e[7] = c[0];
    if (c[7:1] == 7'h53) e[6] = c[0];
    if (c[7:1] == 7'h52) e[5] = c[0];
    if (c[7:1] == 7'h51) breq = c[0];
    if (c[7:4] == 4'hc) e[3] = c[3];
    if (c[7:3] == 5'h05) e[2:0] = c[2:0];
    if (c[7:3] == 5'h04) ratio = c[2:0];
    // Bias only reaches the output with the follower on
    if (e[0]) e[4] = breq;
  endtask : model

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    serial_select = 1'b0;
    scan_page = PAGE_RST;
    scan_col = 8'h03;
    e = 8'h00;
    breq = BIAS_RST;
    ratio = RATIO_RST;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1; // Pin reset at start-up
    repeat (2) @(posedge clk);
    chk(8'(contrast), 8'(CONTRAST_RST));
    chk(cfg, e);
    $display("reset levels done");
    // Fill columns 0..3 inside read-modify-write
    host_u.wr(1'b0, OP_RMW_ON);
    for (int i = 0; i < 4; i++) begin
      mem[i] = xs();
      host_u.wr(1'b1, mem[i]);
      chk(column_addr, 8'(i + 1)); // Write increments
    end
    host_u.wr(1'b0, OP_RMW_OFF);
    chk(column_addr, COL_RST); // Saved column back
    host_u.rd(q, oe); // Dummy read
    for (int i = 0; i < 4; i++) begin
      host_u.rd(q, oe);
      chk(q, mem[i]);
      chk(column_addr, 8'(i + 2));
    end
    $display("write and read done");
    // Reads hold the column in read-modify-write
    host_u.wr(1'b0, OP_RMW_ON);
    host_u.rd(q, oe);
    host_u.rd(q, oe);
    chk(column_addr, 8'h05);
    host_u.wr(1'b1, xs());
    chk(column_addr, 8'h06);
    host_u.wr(1'b0, OP_RMW_OFF);
    chk(column_addr, 8'h05);
    chk(8'(rmw_active), 8'h00);
    // Serial mode refuses reads but takes command and data bytes
    serial_select <= 1'b1;
    host_u.rd(q, oe);
    chk(8'(oe), 8'h01);
    chk(column_addr, 8'h05);
    host_u.swr(1'b0, OP_SCAN | 8'h08);
    model(OP_SCAN | 8'h08);
    chk(cfg, e);
    host_u.swr(1'b1, xs());
    chk(column_addr, 8'h06);
    serial_select <= 1'b0;
    $display("modify and serial done");
    // Clock enable low: a whole strobe pulse must go unseen
    ce <= 1'b0;
    host_u.wr(1'b0, OP_INV | 8'h01);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(cfg, e);
    $display("clock enable done");
    // Random config commands, unknown byte among them
    for (int i = 0; i < 40; i++) begin
      b = xs();
      b = ops[b[2:0]] | (xs() & msk[b[2:0]]);
      host_u.wr(1'b0, b);
      model(b);
      chk(cfg, e);
      chk(8'(resistor_ratio), 8'(ratio));
      scan_col <= e[7] ? SEG_LAST - 8'h03 : 8'h03;
      repeat (3) @(posedge clk);
      chk(scan_pixels, pix(mem[3], e[6], e[5]));
    end
    $display("config commands done");
    // Contrast pair; a command-like value is only data
    host_u.wr(1'b0, OP_CONTRAST);
    chk(8'(contrast_pending), 8'h01);
    host_u.wr(1'b0, 8'ha6 | {7'h00, ~e[6]});
    chk(cfg, e);
    chk(8'(contrast), {2'b00, 5'h13, ~e[6]}); // Low six bits only
    chk(8'(contrast_pending), 8'h00);
    $display("contrast done");
    // Soft reset inside read-modify-write
    host_u.wr(1'b0, OP_RMW_ON);
    host_u.wr(1'b0, OP_SOFT_RST);
    e[3] = 1'b0;
    chk(cfg, e);
    chk(8'(contrast), 8'(CONTRAST_RST));
    chk({resistor_ratio, rmw_active, page_addr}, 8'h00);
    chk(column_addr, COL_RST);
    host_u.rd(q, oe); // Dummy read
    host_u.rd(q, oe);
    chk(q, mem[0]); // Memory kept
    $display("soft reset done");
    // Column stops at the top, page stays
    for (int i = 0; i < 300 && column_addr !== COL_MAX; i++) begin
      host_u.wr(1'b1, xs());
    end
    host_u.wr(1'b1, xs());
    chk(column_addr, COL_MAX);
    chk(8'(page_addr), 8'(PAGE_RST));
    $display("saturation done");
    complete_run();
  end
endmodule : test_lcdc_top
